// ==== tcs_aux_ram_model.sv ====
// Auxiliary microcode RAM model that answers the scheduler in emulation mode
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_aux_ram_model
   import tcs_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic [`TCS_UAW-1:0] emu_addr_i,
   input  wire logic                emu_rd_i,
   output logic      [`TCS_UDW-1:0] emu_data_o
);
   logic [`TCS_UDW-1:0] last_r = '0;
   tcs_uword_t          uw;
   // One-step sequence that links to the channel numbered by its function code, so traffic keeps flowing
   always_comb begin
      uw         = '0;
      uw.fin     = 1'b1;
      uw.irq     = 1'b1;
      uw.link    = 1'b1;
      uw.link_ch = emu_addr_i[8:5];
      uw.pin_act = `TCS_PIN_TGL;
      uw.arm     = 1'b1;
   end
   // Valid within the read cycle as the ROM is; scrambled outside it
   assign emu_data_o = emu_rd_i ? uw : ~last_r;
   always_ff @(posedge sys_clk_i) begin
      if (emu_rd_i) begin
         last_r <= uw;
      end
   end
endmodule

// ==== tcs_cfg.svh ====
// Constants of the timing channel scheduler
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_NCH         16
`define TCS_CHW         4
`define TCS_TBW         16
`define TCS_NPAR        8
`define TCS_PARW        3
`define TCS_PRAMW       7
`define TCS_UAW         9
`define TCS_UDW         32
`define TCS_FNW         4
`define TCS_STW         5
`define TCS_PRIW        2
`define TCS_TB1_BASE    2'h3
`define TCS_SLOT_LAST   3'h6
`define TCS_PRI_OFF     2'h0
`define TCS_PRI_LOW     2'h1
`define TCS_PRI_MID     2'h2
`define TCS_PRI_HIGH    2'h3
`define TCS_PIN_HOLD    2'h0
`define TCS_PIN_HIGH    2'h1
`define TCS_PIN_LOW     2'h2
`define TCS_PIN_TGL     2'h3
`define TCS_FN_CAPTURE  4'h1
`endif

// ==== tcs_chan_if.sv ====
// Engine to channel carrier of the timing channel scheduler
`timescale 1ns/1ps
`include "tcs_cfg.svh"
interface tcs_chan_if;
   logic                wr;
   logic [`TCS_TBW-1:0] evt_w;
   logic                arm;
   logic [1:0]          pin_act;
   logic                tb_sel;
   logic                cap_en;
   logic                link_set;
   logic                svc_clr;
   logic                req;
   logic [`TCS_TBW-1:0] evt_q;
   logic [`TCS_TBW-1:0] cap_q;
   logic                pin;
   logic                pin_oe;
   modport chan (input wr, evt_w, arm, pin_act, tb_sel, cap_en, link_set, svc_clr,
                 output req, evt_q, cap_q, pin, pin_oe);
   modport eng  (output wr, evt_w, arm, pin_act, tb_sel, cap_en, link_set, svc_clr,
                 input req, evt_q, cap_q, pin, pin_oe);
endinterface

// ==== tcs_channel.sv ====
// One timing channel: event register, capture register and pin control
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_channel
   import tcs_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic [`TCS_TBW-1:0] tb1_i,
   input  wire logic [`TCS_TBW-1:0] tb2_i,
   input  wire logic                pin_i,
   tcs_chan_if.chan                 cif
);
   tcs_chan_t           s_r;
   tcs_chan_t           s_nxt;
   logic [`TCS_TBW-1:0] tb;
   // Armed on a zero event at reset: the host has no other way to start a channel,
   // so every channel asks for its first service as soon as reset lets go
   localparam tcs_chan_t CH_RST = '{armed: 1'b1, default: '0};

   assign tb = s_r.tb_sel ? tb2_i : tb1_i;
   assign cif.req    = s_r.req;
   assign cif.evt_q  = s_r.evt;
   assign cif.cap_q  = s_r.cap;
   assign cif.pin    = s_r.pin;
   assign cif.pin_oe = s_r.pin_oe;

   always_comb begin
      s_nxt = s_r;
      s_nxt.pin_d = pin_i;
      if (cif.svc_clr) begin
         s_nxt.req = 1'b0;
      end
      // Private comparator, so every channel can match in the same cycle
      if (s_r.armed && tb == s_r.evt) begin
         s_nxt.armed = 1'b0;
         s_nxt.req   = 1'b1;
         unique case (s_r.pin_act)
            `TCS_PIN_HIGH: s_nxt.pin = 1'b1;
            `TCS_PIN_LOW:  s_nxt.pin = 1'b0;
            `TCS_PIN_TGL:  s_nxt.pin = ~s_r.pin;
            `TCS_PIN_HOLD: s_nxt.pin = s_r.pin;
         endcase
      end
      if (s_r.cap_en && pin_i != s_r.pin_d) begin
         s_nxt.cap = tb;
         s_nxt.req = 1'b1;
      end
      if (cif.wr) begin
         s_nxt.evt     = cif.evt_w;
         s_nxt.armed   = cif.arm;
         s_nxt.pin_act = cif.pin_act;
         s_nxt.tb_sel  = cif.tb_sel;
         s_nxt.cap_en  = cif.cap_en;
         s_nxt.pin_oe  = ~cif.cap_en;
      end
      if (cif.link_set) begin
         s_nxt.req = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= CH_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   AST_MATCH_REQ: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.armed && tb == s_r.evt |=> s_r.req)
      else $error("match did not raise a request");
   AST_MATCH_PIN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.armed && tb == s_r.evt && s_r.pin_act == `TCS_PIN_LOW && !cif.wr |=> !s_r.pin)
      else $error("match did not drive the pin low");
   AST_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.cap_en && pin_i != s_r.pin_d |=> s_r.cap == $past(tb))
      else $error("capture register missed the time base");
   AST_REQ_HOLD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.req && !cif.svc_clr |=> s_r.req)
      else $error("pending request dropped before service");
endmodule

// ==== tcs_pkg.sv ====
// Types shared by the timing channel scheduler modules
`include "tcs_cfg.svh"
package tcs_pkg;
   typedef enum logic [1:0] {TCS_IDLE, TCS_FETCH, TCS_EXEC, TCS_WRB} tcs_eng_t;
   typedef struct packed {
      logic                  fin;
      logic                  irq;
      logic                  link;
      logic [`TCS_CHW-1:0]   link_ch;
      logic                  chg;
      logic [`TCS_CHW-1:0]   chg_ch;
      logic [`TCS_PARW-1:0]  par_idx;
      logic [1:0]            pin_act;
      logic                  tb_sel;
      logic                  cap_en;
      logic                  arm;
      logic [11:0]           spare;
   } tcs_uword_t;
   typedef struct packed {
      logic [`TCS_TBW-1:0]   evt;
      logic [`TCS_TBW-1:0]   cap;
      logic                  armed;
      logic                  pin;
      logic                  pin_oe;
      logic                  pin_d;
      logic [1:0]            pin_act;
      logic                  tb_sel;
      logic                  cap_en;
      logic                  req;
   } tcs_chan_t;
   typedef struct packed {
      logic [`TCS_NCH-1:0]   pin_s1;
      logic [`TCS_NCH-1:0]   pin_s2;
      logic                  tb2_s1;
      logic                  tb2_s2;
      logic                  tb2_s3;
      logic [1:0]            div;
      logic [2:0]            psc1;
      logic [2:0]            psc2;
      logic [`TCS_TBW-1:0]   tb1;
      logic [`TCS_TBW-1:0]   tb2;
      tcs_eng_t              eng;
      logic [`TCS_CHW-1:0]   ch;
      logic [`TCS_STW-1:0]   step;
      tcs_uword_t            uw;
      logic [`TCS_TBW-1:0]   par;
      logic [2:0]            slot;
      logic [2:0][`TCS_CHW-1:0] rr;
      logic [`TCS_NCH-1:0]   irq;
      logic [`TCS_UAW-1:0]   uaddr;
      logic                  urd;
      logic                  lock;
      logic [`TCS_NCH-1:0]   svc;
      logic [`TCS_NCH-1:0]   link;
      logic [`TCS_NCH-1:0]   w_en;
      logic [`TCS_TBW-1:0]   w_evt;
      tcs_uword_t            w_uw;
      logic [`TCS_TBW-1:0]   hrd;
   } tcs_top_t;
endpackage

// ==== tcs_timing_channel_scheduler.sv ====
// Timing channel scheduler: time bases, channels, priority scheduler, microengine
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_timing_channel_scheduler
   import tcs_pkg::*;
#(
   parameter int NCH = `TCS_NCH
)(
   input  wire logic                          sys_clk_i,
   input  wire logic                          sys_rst_i,
   input  wire logic [NCH-1:0]                ch_pin_i,
   output logic      [NCH-1:0]                ch_pin_o,
   output logic      [NCH-1:0]                ch_pin_oe_o,
   input  wire logic                          tb2_pin_i,
   input  wire logic [1:0]                    tb1_psc_i,
   input  wire logic [1:0]                    tb2_psc_i,
   input  wire logic [NCH*`TCS_PRIW-1:0]      ch_prio_i,
   input  wire logic [NCH*`TCS_FNW-1:0]       ch_func_i,
   input  wire logic [NCH-1:0]                ch_irq_en_i,
   input  wire logic [NCH-1:0]                irq_clr_i,
   output logic      [NCH-1:0]                ch_irq_o,
   input  wire logic                          hpar_we_i,
   input  wire logic [`TCS_PRAMW-1:0]         hpar_addr_i,
   input  wire logic [`TCS_TBW-1:0]           hpar_wdata_i,
   output logic      [`TCS_TBW-1:0]           hpar_rdata_o,
   input  wire logic                          emu_mode_i,
   output logic      [`TCS_UAW-1:0]           emu_addr_o,
   output logic                               emu_rd_o,
   input  wire logic [`TCS_UDW-1:0]           emu_data_i,
   output logic                               emu_bus_lock_o
);
   tcs_top_t                 s_r;
   tcs_top_t                 s_nxt;
   logic [`TCS_TBW-1:0]      pram [0:NCH*`TCS_NPAR-1];
   logic [NCH-1:0]           req_v;
   logic [NCH-1:0]           mask_h;
   logic [NCH-1:0]           mask_m;
   logic [NCH-1:0]           mask_l;
   logic [`TCS_TBW-1:0]      evt_v [0:NCH-1];
   logic [4:0]               pick_h;
   logic [4:0]               pick_m;
   logic [4:0]               pick_l;
   logic [4:0]               sel;
   logic [1:0]               sel_lvl;
   logic [`TCS_CHW-1:0]      tgt;

   ////////////////////////////////////////////////////////////////////////////////
   // Channels

   generate
      for (genvar g = 0; g < NCH; g++) begin : g_ch
         tcs_chan_if cif ();
         // Every channel is the same module, so any function runs anywhere
         tcs_channel u_ch (
            .sys_clk_i (sys_clk_i),
            .sys_rst_i (sys_rst_i),
            .tb1_i     (s_r.tb1),
            .tb2_i     (s_r.tb2),
            .pin_i     (s_r.pin_s2[g]),
            .cif       (cif)
         );
         assign cif.wr       = s_r.w_en[g];
         assign cif.evt_w    = s_r.w_evt;
         assign cif.arm      = s_r.w_uw.arm;
         assign cif.pin_act  = s_r.w_uw.pin_act;
         assign cif.tb_sel   = s_r.w_uw.tb_sel;
         assign cif.cap_en   = s_r.w_uw.cap_en;
         assign cif.link_set = s_r.link[g];
         assign cif.svc_clr  = s_r.svc[g];
         assign req_v[g]     = cif.req;
         assign evt_v[g]     = cif.evt_q;
         assign ch_pin_o[g]    = cif.pin;
         assign ch_pin_oe_o[g] = cif.pin_oe;
         assign mask_h[g] = cif.req && ch_prio_i[g*`TCS_PRIW +: `TCS_PRIW] == `TCS_PRI_HIGH;
         assign mask_m[g] = cif.req && ch_prio_i[g*`TCS_PRIW +: `TCS_PRIW] == `TCS_PRI_MID;
         assign mask_l[g] = cif.req && ch_prio_i[g*`TCS_PRIW +: `TCS_PRIW] == `TCS_PRI_LOW;
      end
   endgenerate

   assign ch_irq_o       = s_r.irq;
   assign emu_addr_o     = s_r.uaddr;
   assign emu_rd_o       = s_r.urd;
   assign emu_bus_lock_o = s_r.lock;
   assign hpar_rdata_o   = s_r.hrd;

   ////////////////////////////////////////////////////////////////////////////////
   // Scheduler helpers

   // Round robin within one level: first request at or after the pointer
   function automatic logic [4:0] tcs_pick(input logic [NCH-1:0] m,
                                           input logic [`TCS_CHW-1:0] p);
      logic [4:0]          r;
      logic [`TCS_CHW-1:0] k;
      r = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         k = p + `TCS_CHW'(i);
         if (m[k]) begin
            r = {1'b1, k};
         end
      end
      return r;
   endfunction

   // Slot wheel H M H L H M H: low level always gets a slot, so no starvation
   function automatic logic [1:0] tcs_slot_lvl(input logic [2:0] sl);
      logic [1:0] l;
      unique case (sl)
         3'h1, 3'h5: l = `TCS_PRI_MID;
         3'h3:       l = `TCS_PRI_LOW;
         default:    l = `TCS_PRI_HIGH;
      endcase
      return l;
   endfunction

   // On-chip control store; two built-in functions, others via emulation
   function automatic tcs_uword_t tcs_rom(input logic [`TCS_UAW-1:0] a);
      tcs_uword_t w;
      w         = '0;
      w.fin     = 1'b1;
      w.irq     = 1'b1;
      w.arm     = 1'b1;
      w.pin_act = `TCS_PIN_TGL;
      if (a[`TCS_UAW-1 -: `TCS_FNW] == `TCS_FN_CAPTURE) begin
         w.arm     = 1'b0;
         w.cap_en  = 1'b1;
         w.pin_act = `TCS_PIN_HOLD;
      end
      return w;
   endfunction

   assign pick_h = tcs_pick(mask_h, s_r.rr[0]);
   assign pick_m = tcs_pick(mask_m, s_r.rr[1]);
   assign pick_l = tcs_pick(mask_l, s_r.rr[2]);
   assign tgt    = s_r.uw.chg ? s_r.uw.chg_ch : s_r.ch;

   always_comb begin
      sel     = '0;
      sel_lvl = `TCS_PRI_OFF;
      if (tcs_slot_lvl(s_r.slot) == `TCS_PRI_MID && pick_m[4]) begin
         sel     = pick_m;
         sel_lvl = `TCS_PRI_MID;
      end else if (tcs_slot_lvl(s_r.slot) == `TCS_PRI_LOW && pick_l[4]) begin
         sel     = pick_l;
         sel_lvl = `TCS_PRI_LOW;
      end else if (pick_h[4]) begin
         sel     = pick_h;
         sel_lvl = `TCS_PRI_HIGH;
      end else if (pick_m[4]) begin
         sel     = pick_m;
         sel_lvl = `TCS_PRI_MID;
      end else if (pick_l[4]) begin
         sel     = pick_l;
         sel_lvl = `TCS_PRI_LOW;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter RAM: host port and engine port

   always_ff @(posedge sys_clk_i) begin
      if (hpar_we_i) begin
         pram[hpar_addr_i] <= hpar_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_nxt        = s_r;
      s_nxt.pin_s1 = ch_pin_i;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.tb2_s1 = tb2_pin_i;
      s_nxt.tb2_s2 = s_r.tb2_s1;
      s_nxt.tb2_s3 = s_r.tb2_s2;
      s_nxt.svc    = '0;
      s_nxt.link   = '0;
      s_nxt.w_en   = '0;
      s_nxt.urd    = 1'b0;
      s_nxt.lock   = emu_mode_i;
      s_nxt.hrd    = pram[hpar_addr_i];
      // First time base: clock divided by four, then the prescaler
      s_nxt.div = s_r.div + 2'h1;
      if (s_r.div == `TCS_TB1_BASE) begin
         if (s_r.psc1 >= (3'h1 << tb1_psc_i) - 3'h1) begin
            s_nxt.psc1 = '0;
            s_nxt.tb1  = s_r.tb1 + `TCS_TBW'(1);
         end else begin
            s_nxt.psc1 = s_r.psc1 + 3'h1;
         end
      end
      // Second time base counts rising edges of its pin
      if (s_r.tb2_s2 && !s_r.tb2_s3) begin
         if (s_r.psc2 >= (3'h1 << tb2_psc_i) - 3'h1) begin
            s_nxt.psc2 = '0;
            s_nxt.tb2  = s_r.tb2 + `TCS_TBW'(1);
         end else begin
            s_nxt.psc2 = s_r.psc2 + 3'h1;
         end
      end
      s_nxt.irq = s_r.irq & ~irq_clr_i;
      unique case (s_r.eng)
         TCS_IDLE: begin
            if (sel[4]) begin
               s_nxt.ch    = sel[`TCS_CHW-1:0];
               s_nxt.step  = '0;
               s_nxt.uaddr = {ch_func_i[{sel[`TCS_CHW-1:0], 2'h0} +: `TCS_FNW],
                              `TCS_STW'(0)};
               s_nxt.urd   = 1'b1;
               s_nxt.svc[sel[`TCS_CHW-1:0]] = 1'b1;
               s_nxt.slot  = (s_r.slot == `TCS_SLOT_LAST) ? 3'h0 : s_r.slot + 3'h1;
               unique case (sel_lvl)
                  `TCS_PRI_MID: s_nxt.rr[1] = sel[`TCS_CHW-1:0] + `TCS_CHW'(1);
                  `TCS_PRI_LOW: s_nxt.rr[2] = sel[`TCS_CHW-1:0] + `TCS_CHW'(1);
                  default:      s_nxt.rr[0] = sel[`TCS_CHW-1:0] + `TCS_CHW'(1);
               endcase
               s_nxt.eng = TCS_FETCH;
            end
         end
         TCS_FETCH: begin
            // Same one-cycle fetch from either store keeps emulation exact
            s_nxt.uw  = emu_mode_i ? tcs_uword_t'(emu_data_i) : tcs_rom(s_r.uaddr);
            s_nxt.eng = TCS_EXEC;
         end
         TCS_EXEC: begin
            s_nxt.par = pram[{tgt, s_r.uw.par_idx}];
            s_nxt.eng = TCS_WRB;
         end
         TCS_WRB: begin
            s_nxt.w_en[tgt] = 1'b1;
            s_nxt.w_uw      = s_r.uw;
            s_nxt.w_evt     = s_r.uw.arm ? evt_v[tgt] + s_r.par : evt_v[tgt];
            if (s_r.uw.link) begin
               s_nxt.link[s_r.uw.link_ch] = 1'b1;
            end
            if (s_r.uw.fin) begin
               if (s_r.uw.irq && ch_irq_en_i[s_r.ch]) begin
                  s_nxt.irq[s_r.ch] = 1'b1;
               end
               s_nxt.eng = TCS_IDLE;
            end else begin
               s_nxt.step  = s_r.step + `TCS_STW'(1);
               s_nxt.uaddr = {s_r.uaddr[`TCS_UAW-1 -: `TCS_FNW], s_r.step + `TCS_STW'(1)};
               s_nxt.urd   = 1'b1;
               s_nxt.eng   = TCS_FETCH;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   AST_IDLE_START: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.eng == TCS_IDLE && |(mask_h | mask_m | mask_l)
      |=> s_r.eng == TCS_FETCH && s_r.svc[s_r.ch])
      else $error("idle engine did not start on a pending request");
   AST_NO_PREEMPT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.eng != TCS_IDLE && !(s_r.eng == TCS_WRB && s_r.uw.fin) |=> $stable(s_r.ch))
      else $error("running sequence was preempted");
   AST_IRQ_GATE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (ch_irq_o & ~$past(ch_irq_o)) != '0
      |-> $past(s_r.eng == TCS_WRB)
          && (ch_irq_o & ~$past(ch_irq_o) & ~$past(ch_irq_en_i)) == '0)
      else $error("interrupt raised without enable or end of service");
   AST_FETCH_TIME: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      emu_rd_o |-> s_r.eng == TCS_FETCH ##1 s_r.eng == TCS_EXEC ##1 s_r.eng == TCS_WRB)
      else $error("fetch timing broke");
   AST_TB1_STEP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      s_r.tb1 != $past(s_r.tb1) |-> $past(s_r.div) == `TCS_TB1_BASE)
      else $error("first time base stepped off the divided clock");
endmodule

// ==== tcs_timing_channel_scheduler_test.sv ====
// Self-checking bench of the timing channel scheduler
`timescale 1ns/1ps
`include "tcs_cfg.svh"
module tcs_timing_channel_scheduler_test
   import tcs_pkg::*;
;
   logic        sys_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [15:0] ch_pin_i, ch_pin_o, ch_pin_oe_o, ch_irq_en_i, irq_clr_i, ch_irq_o;
   logic        tb2_pin_i, hpar_we_i, emu_mode_i, emu_rd_o, emu_bus_lock_o;
   logic [1:0]  tb1_psc_i, tb2_psc_i;
   logic [31:0] ch_prio_i, emu_data_i;
   logic [63:0] ch_func_i;
   logic [6:0]  hpar_addr_i;
   logic [15:0] hpar_wdata_i, hpar_rdata_o;
   logic [8:0]  emu_addr_o;
   logic [31:0] seed = 32'h0001_3524;
   logic [31:0] r;
   logic [15:0] shadow [128];
   bit          valid [128];
   bit          mon = 1'b0;
   logic [15:0] served = '0;
   logic [15:0] act = '0;
   int          gap = 100;
   int          num_errors = 0;
   int          check_count = 0;

   tcs_timing_channel_scheduler tcs_timing_channel_scheduler_inst (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ch_pin_i(ch_pin_i),
      .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o), .tb2_pin_i(tb2_pin_i),
      .tb1_psc_i(tb1_psc_i), .tb2_psc_i(tb2_psc_i), .ch_prio_i(ch_prio_i),
      .ch_func_i(ch_func_i), .ch_irq_en_i(ch_irq_en_i), .irq_clr_i(irq_clr_i),
      .ch_irq_o(ch_irq_o), .hpar_we_i(hpar_we_i), .hpar_addr_i(hpar_addr_i),
      .hpar_wdata_i(hpar_wdata_i), .hpar_rdata_o(hpar_rdata_o),
      .emu_mode_i(emu_mode_i), .emu_addr_o(emu_addr_o), .emu_rd_o(emu_rd_o),
      .emu_data_i(emu_data_i), .emu_bus_lock_o(emu_bus_lock_o));

   tcs_aux_ram_model tcs_aux_ram_model_inst (
      .sys_clk_i(sys_clk_i), .emu_addr_i(emu_addr_o), .emu_rd_i(emu_rd_o),
      .emu_data_o(emu_data_i));

   always #5 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Channels with a nonzero priority level are the ones the scheduler must serve
   function automatic logic [15:0] active(input logic [31:0] p);
      logic [15:0] a;
      for (int g = 0; g < 16; g++) a[g] = p[2*g +: 2] != 2'h0;
      return a;
   endfunction

   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Random pin traffic; pins only toggle now and then so syncs see real edges
   task automatic step();
      @(posedge sys_clk_i);
      r = rnd();
      ch_pin_i  <= ch_pin_i ^ (r[15:0] & r[31:16]);
      tb2_pin_i <= r[20];
   endtask

   task automatic reset_check();
      check("reset outputs", {ch_pin_o, ch_pin_oe_o, ch_irq_o, emu_rd_o, emu_addr_o,
            emu_bus_lock_o}, 64'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Fetch spacing, priority and interrupt enable watched on every cycle
   always @(posedge sys_clk_i) begin
      #1;
      gap++;
      if (mon && emu_rd_o === 1'b1) begin
         check("fetch gap", gap >= 4, 1);
         check("fetch prio", ch_prio_i[2*emu_addr_o[8:5] +: 2] != 2'h0, 1);
         check("fetch step", emu_addr_o[4:0], 0);
         served[emu_addr_o[8:5]] = 1'b1;
         gap = 0;
      end
      if (mon) begin
         check("irq enable", ch_irq_o & ~ch_irq_en_i, 0);
      end
   end

   initial begin
      #200000;
      num_errors++;
      summarize();
   end

   initial begin
      ch_pin_i = '0; tb2_pin_i = 1'b0; tb1_psc_i = '0; tb2_psc_i = '0;
      ch_prio_i = '0; irq_clr_i = '0; hpar_we_i = 1'b0; hpar_addr_i = '0;
      hpar_wdata_i = '0; emu_mode_i = 1'b0; ch_irq_en_i = 16'hA5C3;
      for (int g = 0; g < 16; g++) ch_func_i[4*g +: 4] = 4'(g);
      repeat (3) @(posedge sys_clk_i);
      #1;
      reset_check();
      @(posedge sys_clk_i) sys_rst_i <= 1'b0;
      emu_mode_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      check("bus lock", emu_bus_lock_o, 1);
      // Every word gets a value first, so the engine never adds an unknown duration
      for (int a = 0; a < 128; a++) begin
         @(posedge sys_clk_i);
         r = rnd();
         hpar_we_i    <= 1'b1;
         hpar_addr_i  <= 7'(a);
         hpar_wdata_i <= r[15:0];
         shadow[a] = r[15:0];
         valid[a]  = 1'b1;
      end
      for (int i = 0; i < 24; i++) begin
         @(posedge sys_clk_i);
         r = rnd();
         hpar_we_i    <= 1'b1;
         hpar_addr_i  <= r[6:0];
         hpar_wdata_i <= r[31:16];
         shadow[r[6:0]] = r[31:16];
         valid[r[6:0]]  = 1'b1;
      end
      @(posedge sys_clk_i) hpar_we_i <= 1'b0;
      for (int a = 0; a < 128; a++) begin
         if (valid[a]) begin
            @(posedge sys_clk_i) hpar_addr_i <= 7'(a);
            @(posedge sys_clk_i);
            #1;
            check("param read", hpar_rdata_o, shadow[a]);
         end
      end
      mon = 1'b1;
      repeat (200) step();
      r = rnd();
      ch_prio_i <= r | 32'h0000_00CC;
      act = active(r | 32'h0000_00CC);
      tb1_psc_i <= r[1:0];
      tb2_psc_i <= r[3:2];
      repeat (3000) step();
      check("all served", served, act);
      // Back to the on-chip store: channel 1 runs the capture function there
      emu_mode_i <= 1'b0;
      repeat (300) step();
      #1;
      check("pin enable", ch_pin_oe_o, act & 16'hFFFD);
      check("irq set", ch_irq_o, act & ch_irq_en_i);
      mon = 1'b0;
      ch_prio_i  <= '0;
      emu_mode_i <= 1'b0;
      repeat (20) step();
      check("bus unlock", emu_bus_lock_o, 0);
      @(posedge sys_clk_i) irq_clr_i <= 16'hFFFF;
      @(posedge sys_clk_i) irq_clr_i <= '0;
      #1;
      check("irq clear", ch_irq_o, 0);
      @(posedge sys_clk_i) sys_rst_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      reset_check();
      summarize();
   end
endmodule
